// ### iile_exec.sv
// Purpose: execute inc, inc-with-carry, interrupt return and loop ops
// Assumes: one op per cycle, all single cycle; APB slave, zero wait
// Notes:   APB writes land after the op of the same cycle
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iile_exec
  import iile_pkg::*;
#(
  parameter int HS_DEPTH = 16
)
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // decoded instruction
  input  wire logic        OP_VALID,
  input  wire logic [2:0]  OP_CODE,
  input  wire logic [1:0]  OP_BANK,
  input  wire logic [1:0]  OP_REG,
  input  wire logic [7:0]  OP_IMM,
  // interrupt gate
  input  wire logic        INT_PENDING,
  output logic             INT_ACCEPT,
  // core state
  output logic [19:0]      PC_OUT,
  output logic [3:0]       FLAGS_OUT,
  output logic [7:0]       SR0_OUT,
  output logic [7:0]       SPTR_OUT,
  output logic             DELAY_SLOT,
  output logic             ILLEGAL_OP
);
  localparam int HS_AW = $clog2(HS_DEPTH);

  // the pointer is eight bits and steps by two, so deeper stacks would wrap
  if (HS_DEPTH < 2 || HS_DEPTH > 64 || (1 << HS_AW) != HS_DEPTH) begin : g_bad_depth
    $error("HS_DEPTH must be a power of two from 2 to 64");
  end

  // ==========================================
  // state
  typedef struct packed {
    logic [PC_W-1:0]                 pc;
    logic [7:0]                      sr0;
    logic [3:0]                      flg;
    logic [7:0]                      sptr;
    logic [HS_DEPTH-1:0][PC_W-1:0]   hs;
    logic [15:0][7:0]                gpr;
    logic                            br_pend;
    logic [PC_W-1:0]                 br_tgt;
    logic                            ill;
    logic                            small_n;
    logic [31:0]                     rdata;
    logic                            slverr;
  } iile_state_s;

  iile_state_s s_r;
  iile_state_s s_nxt;

  // ==========================================
  // operand fetch and alu
  logic [3:0]      idx;
  logic [7:0]      opnd;
  logic [7:0]      alu_res;
  logic [3:0]      alu_flg;
  logic [PC_W-1:0] pc_seq;
  logic [HS_AW-1:0] top_idx;
  logic [HS_AW-1:0] push_idx;
  logic [PC_W-1:0] top_ent;
  logic            hs_empty;
  logic            hs_full;
  logic            apb_wr;
  logic            apb_setup;
  logic            gpr_hit;

  assign idx      = {OP_BANK, OP_REG};
  assign opnd     = s_r.gpr[idx];
  assign pc_seq   = s_r.pc + 20'h00001;
  // pointer steps by two, entries are indexed by pointer / 2
  assign push_idx = s_r.sptr[HS_AW:1];
  assign top_idx  = push_idx - {{(HS_AW-1){1'b0}}, 1'b1};
  assign top_ent  = s_r.hs[top_idx];
  assign hs_empty = (s_r.sptr < SPTR_STEP);
  assign hs_full  = (s_r.sptr[7:1] >= 7'(HS_DEPTH));
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE;
  assign gpr_hit   = (PADDR[7:6] == A_GPR_HI) && (PADDR[1:0] == 2'h0);

  // ==========================================
  // apb address decode
  logic        sel_sr0;
  logic        sel_flg;
  logic        sel_pc;
  logic        sel_sptr;
  logic        sel_stack;
  logic        sel_cfg;
  logic        sel_none;
  logic [31:0] rd_word;

  assign sel_sr0   = ~gpr_hit & (PADDR == A_SR0);
  assign sel_flg   = ~gpr_hit & (PADDR == A_FLAGS);
  assign sel_pc    = ~gpr_hit & (PADDR == A_PC);
  assign sel_sptr  = ~gpr_hit & (PADDR == A_SPTR);
  assign sel_stack = ~gpr_hit & (PADDR == A_STACK);
  assign sel_cfg   = ~gpr_hit & (PADDR == A_CFG);
  // anything outside the map is refused with an error
  assign sel_none  = ~gpr_hit & ~(sel_sr0 | sel_flg | sel_pc | sel_sptr | sel_stack | sel_cfg);

  // narrow fields sit in the low bits, upper bits read zero
  always_comb begin
    rd_word = 32'h00000000;

    if (gpr_hit) begin
      rd_word[7:0] = s_r.gpr[PADDR[5:2]];
    end

    if (sel_sr0) begin
      rd_word[7:0] = s_r.sr0;
    end

    if (sel_flg) begin
      rd_word[3:0] = s_r.flg;
    end

    if (sel_pc) begin
      rd_word[PC_W-1:0] = s_r.pc;
    end

    if (sel_sptr) begin
      rd_word[7:0] = s_r.sptr;
    end

    // an empty stack reads zero rather than a stale entry
    if (sel_stack && !hs_empty) begin
      rd_word[PC_W-1:0] = top_ent;
    end

    if (sel_cfg) begin
      rd_word[0] = s_r.small_n;
    end
  end

  // ==========================================
  // op decode
  logic            op_inc;
  logic            op_increment_with_carry_op;
  logic            op_interrupt_return_op;
  logic            op_loop;
  logic            interrupt_return_op_ok;
  logic            loop_ok;
  logic            loop_take;
  logic            op_gpr_we;
  logic [7:0]      op_gpr_val;
  logic [PC_W-1:0] loop_tgt;

  assign op_inc     = OP_VALID & (OP_CODE == OP_INC);
  assign op_increment_with_carry_op    = OP_VALID & (OP_CODE == OP_INCREMENT_WITH_CARRY_OP);
  assign op_interrupt_return_op    = OP_VALID & (OP_CODE == OP_INTERRUPT_RETURN_OP);
  assign op_loop    = OP_VALID & (OP_CODE == OP_LOOP);
  // an empty stack has no return address, so the return is refused
  assign interrupt_return_op_ok    = op_interrupt_return_op & ~hs_empty;
  assign loop_ok    = op_loop & (OP_BANK == LOOP_BANK);
  // counter tested before the decrement
  assign loop_take  = loop_ok & (opnd != 8'h00);
  assign loop_tgt   = pc_seq + {{12{OP_IMM[7]}}, OP_IMM};
  assign op_gpr_we  = op_inc | op_increment_with_carry_op | loop_ok;
  assign op_gpr_val = loop_ok ? (opnd - 8'h01) : alu_res;

  // ==========================================
  // general registers, one write lane each
  logic [7:0] gpr_nxt [16];

  for (genvar gi = 0; gi < 16; gi++) begin : g_gpr
    logic op_we;
    logic bus_we;

    assign op_we  = op_gpr_we & (idx == 4'(gi));
    assign bus_we = apb_wr & gpr_hit & (PADDR[5:2] == 4'(gi));
    // bus write wins over an op on the same register
    assign gpr_nxt[gi] = bus_we ? PWDATA[7:0] : (op_we ? op_gpr_val : s_r.gpr[gi]);
  end

  iile_alu u_alu (
    .a          (opnd),
    .carry_in   (s_r.flg[FC]),
    .with_carry (OP_CODE == OP_INCREMENT_WITH_CARRY_OP),
    .result     (alu_res),
    .flags      (alu_flg)
  );

  // ==========================================
  // next state
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ill = 1'b0;
    if (OP_VALID) begin
      s_nxt.pc = pc_seq;
      unique case (OP_CODE)
        OP_NOP: begin
        end
        OP_INC, OP_INCREMENT_WITH_CARRY_OP: begin
          s_nxt.flg      = alu_flg;
        end
        OP_INTERRUPT_RETURN_OP: begin
          // flags untouched on this path
          if (!interrupt_return_op_ok) begin
            s_nxt.ill = 1'b1;
          end else begin
            if (!s_r.small_n) begin
              s_nxt.pc[PC_SMALL_W-1:0] = top_ent[PC_SMALL_W-1:0];
              s_nxt.pc[PC_W-1:PC_SMALL_W] = s_r.pc[PC_W-1:PC_SMALL_W];
            end else begin
              s_nxt.pc = top_ent;
            end
            s_nxt.sptr        = s_r.sptr - SPTR_STEP;
            s_nxt.sr0[IE_BIT] = 1'b1;
          end
        end
        OP_LOOP: begin
          // flags untouched on this path
          if (!loop_ok) begin
            s_nxt.ill = 1'b1;
          end else begin
            if (loop_take) begin
              s_nxt.br_pend = 1'b1;
              s_nxt.br_tgt  = loop_tgt;
            end
          end
        end
        default: begin
          s_nxt.ill = 1'b1;
        end
      endcase
      // slot op runs, then the taken branch redirects; a loop in the slot
      // cannot chain: the redirect clears br_pend and drops the slot loop's own branch
      if (s_r.br_pend) begin
        s_nxt.pc      = s_r.br_tgt;
        s_nxt.br_pend = 1'b0;
      end
    end
    // ==========================================
    // apb read in setup, write in access
    if (apb_setup) begin
      s_nxt.slverr = sel_none;
      s_nxt.rdata  = rd_word;
    end
    if (apb_wr) begin
      if (gpr_hit) begin
        // gpr lanes take the write in g_gpr
      end else begin
        unique case (PADDR)
          A_SR0:   s_nxt.sr0 = PWDATA[7:0];
          A_FLAGS: s_nxt.flg = PWDATA[3:0];
          A_PC:    s_nxt.pc = PWDATA[PC_W-1:0];
          A_SPTR:  s_nxt.sptr = PWDATA[7:0];
          A_STACK: begin
            // a push into a full stack is dropped
            if (!hs_full) begin
              s_nxt.hs[push_idx] = PWDATA[PC_W-1:0];
              s_nxt.sptr         = s_r.sptr + SPTR_STEP;
            end
          end
          A_CFG:   s_nxt.small_n = PWDATA[0];
          default: begin
          end
        endcase
      end
    end
    for (int k = 0; k < 16; k++) begin
      s_nxt.gpr[k] = gpr_nxt[k];
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r         <= '0;
      s_r.sr0     <= SR0_RST;
      s_r.flg     <= FLAGS_RST;
      s_r.sptr    <= SPTR_RST;
      s_r.small_n <= SMALL_N_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // outputs
  assign PRDATA     = s_r.rdata;
  assign PSLVERR    = s_r.slverr & PSEL & PENABLE;
  assign PREADY     = 1'b1;
  // interrupts wait while a branch is pending so the slot is not split
  assign INT_ACCEPT = INT_PENDING & s_r.sr0[IE_BIT] & ~s_r.br_pend;
  assign PC_OUT     = s_r.pc;
  assign FLAGS_OUT  = s_r.flg;
  assign SR0_OUT    = s_r.sr0;
  assign SPTR_OUT   = s_r.sptr;
  assign DELAY_SLOT = s_r.br_pend;
  assign ILLEGAL_OP = s_r.ill;
endmodule
`default_nettype wire

// ### iile_pkg.sv
// Purpose: constants for the increment / return / loop execution block
// Assumes: one core clock, APB register access
// Notes:   offsets are byte addresses on a 32-bit APB
package iile_pkg;
  // ==========================================
  // operation codes
  typedef enum logic [2:0] {
    OP_NOP  = 3'h0,
    OP_INC  = 3'h1,
    OP_INCREMENT_WITH_CARRY_OP = 3'h2,
    OP_INTERRUPT_RETURN_OP = 3'h3,
    OP_LOOP = 3'h4
  } iile_op_e;
  // ==========================================
  // register offsets
  localparam logic [7:0] A_SR0   = 8'h00;
  localparam logic [7:0] A_FLAGS = 8'h04;
  localparam logic [7:0] A_PC    = 8'h08;
  localparam logic [7:0] A_SPTR  = 8'h0c;
  localparam logic [7:0] A_STACK = 8'h10;
  localparam logic [7:0] A_CFG   = 8'h14;
  localparam logic [1:0] A_GPR_HI = 2'h1;
  // ==========================================
  // fields and reset values
  localparam int         PC_W       = 20;
  localparam int         PC_SMALL_W = 16;
  localparam int         IE_BIT     = 1;
  localparam int         FC = 0;
  localparam int         FZ = 1;
  localparam int         FV = 2;
  localparam int         FN = 3;
  localparam logic [1:0] LOOP_BANK  = 2'h3;
  localparam logic [7:0] SR0_RST    = 8'h00;
  localparam logic [3:0] FLAGS_RST  = 4'h0;
  localparam logic [7:0] SPTR_RST   = 8'h00;
  localparam logic [7:0] SPTR_STEP  = 8'h02;
  localparam logic       SMALL_N_RST = 1'b1;
endpackage

// ### iile_alu.sv
// Purpose: 8-bit increment and increment-with-carry with flags
// Assumes: purely combinational, same clock as caller
// Notes:   flag order in flags is {N,V,Z,C}
`timescale 1ns/1ps
`default_nettype none
module iile_alu
  import iile_pkg::*;
(
  // operands
  input  wire logic [7:0] a,
  input  wire logic       carry_in,
  input  wire logic       with_carry,
  // results
  output logic      [7:0] result,
  output logic      [3:0] flags
);
  logic [8:0] sum;
  logic       add_one;
  logic       ovf;

  always_comb begin
    add_one = with_carry ? carry_in : 1'b1;
    sum     = {1'b0, a} + {8'h00, add_one};
    result  = sum[7:0];
    // only 7f plus one can overflow an increment
    ovf       = ~a[7] & sum[7];
    flags[FC] = sum[8];
    flags[FZ] = (sum[7:0] == 8'h00);
    flags[FV] = ovf;
    flags[FN] = with_carry ? (ovf ^ sum[7]) : sum[7];
  end
endmodule
`default_nettype wire

// ### iile_assertions.sv
// Purpose: port checks for iile_exec
// Assumes: flags {N,V,Z,C}
// Notes:   loop target kept in tgt_r
`timescale 1ns/1ps
`default_nettype none
module iile_assertions
  import iile_pkg::*;
(
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST_B,
  // ops
  input wire logic        OP_VALID,
  input wire logic [2:0]  OP_CODE,
  input wire logic [1:0]  OP_BANK,
  input wire logic [7:0]  OP_IMM,
  input wire logic        INT_PENDING,
  // state
  input wire logic        INT_ACCEPT,
  input wire logic [19:0] PC_OUT,
  input wire logic [3:0]  FLAGS_OUT,
  input wire logic [7:0]  SR0_OUT,
  input wire logic [7:0]  SPTR_OUT,
  input wire logic        DELAY_SLOT,
  input wire logic        ILLEGAL_OP
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================
  // helpers
  // slot edge overwrites it, so read one edge late
  logic [19:0] tgt_r;
  wire         ret = OP_VALID && OP_CODE == 3'h3 && SPTR_OUT >= 8'h02;
  wire         lp  = OP_VALID && OP_CODE == 3'h4;
  always_ff @(posedge CORE_CLK) tgt_r <= PC_OUT + 20'h1 + {{12{OP_IMM[7]}}, OP_IMM};
  sequence s_taken;
    lp && OP_BANK == 2'h3 ##1 DELAY_SLOT;
  endsequence
  // ==========================================
  // properties
  property p_ret_sp; ret |=> SPTR_OUT == $past(SPTR_OUT) - 8'h02; endproperty
  a_ret_sp: assert property (p_ret_sp) else $error("sptr not down by two");
  property p_ret_ie; ret |=> SR0_OUT[IE_BIT]; endproperty
  a_ret_ie: assert property (p_ret_ie) else $error("enable not set");
  property p_ret_fl; ret |=> $stable(FLAGS_OUT); endproperty
  a_ret_fl: assert property (p_ret_fl) else $error("return moved flags");
  property p_lp_fl; lp |=> $stable(FLAGS_OUT); endproperty
  a_lp_fl: assert property (p_lp_fl) else $error("loop moved flags");
  property p_bank; lp && OP_BANK != 2'h3 |=> ILLEGAL_OP && !DELAY_SLOT; endproperty
  a_bank: assert property (p_bank) else $error("bad bank taken");
  property p_slot; DELAY_SLOT && OP_VALID |=> !DELAY_SLOT; endproperty
  a_slot: assert property (p_slot) else $error("slot not consumed");
  property p_tgt; s_taken ##0 OP_VALID |=> PC_OUT == $past(tgt_r); endproperty
  a_tgt: assert property (p_tgt) else $error("wrong loop target");
  property p_gate; INT_ACCEPT == (INT_PENDING && SR0_OUT[IE_BIT] && !DELAY_SLOT); endproperty
  a_gate: assert property (p_gate) else $error("interrupt gate wrong");
endmodule
bind iile_exec iile_assertions chk_i (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .OP_BANK(OP_BANK), .OP_IMM(OP_IMM), .INT_PENDING(INT_PENDING),
  .INT_ACCEPT(INT_ACCEPT), .PC_OUT(PC_OUT), .FLAGS_OUT(FLAGS_OUT), .SR0_OUT(SR0_OUT),
  .SPTR_OUT(SPTR_OUT), .DELAY_SLOT(DELAY_SLOT), .ILLEGAL_OP(ILLEGAL_OP));
`default_nettype wire

// ### iile_exec_tb.sv
// Purpose: self-checking bench for iile_exec
// Assumes: APB zero wait, gpr n at 8'h40+4n
// Notes:   one op per task call
`timescale 1ns/1ps
`default_nettype none
module iile_exec_tb
  import iile_pkg::*;
();
  logic        clk, rb = 1'b0, ps = 1'b0, pe = 1'b0, pw = 1'b0, ov = 1'b0, ip = 1'b0;
  logic        rdy, er, ia, ds, il, x;
  logic [2:0]  oc = 3'h0;
  logic [1:0]  ob = 2'h0, orr = 2'h0;
  logic [7:0]  pa = 8'h0, oi = 8'h0, sr, sp;
  logic [31:0] wd = 32'h0, rd, q;
  logic [19:0] pc;
  logic [3:0]  fl;
  int          err_count = 0, comparisons = 0;
  iile_exec uut (.CORE_CLK(clk), .RST_B(rb), .PSEL(ps), .PENABLE(pe), .PWRITE(pw),
    .PADDR(pa), .PWDATA(wd), .PRDATA(rd), .PREADY(rdy), .PSLVERR(er), .OP_VALID(ov),
    .OP_CODE(oc), .OP_BANK(ob), .OP_REG(orr), .OP_IMM(oi), .INT_PENDING(ip),
    .INT_ACCEPT(ia), .PC_OUT(pc), .FLAGS_OUT(fl), .SR0_OUT(sr), .SPTR_OUT(sp),
    .DELAY_SLOT(ds), .ILLEGAL_OP(il));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // zero-wait slave, but the wait stays bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    ps <= 1'b1;
    pw <= w;
    pa <= a;
    wd <= d;
    @(posedge clk);
    pe <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) begin
      err_count++;
    end
    q = rd;
    x = er;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [7:0] m);
    @(posedge clk);
    ov <= 1'b1;
    oc <= c;
    ob <= b;
    oi <= m;
    @(posedge clk);
    ov <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    err_count++;
    summarize();
  end
  // ==========================================
  // tests
  initial begin
    repeat (5) @(posedge clk);
    rb <= 1'b1;
    rc(A_CFG, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, x}, 32'h1);
    $display("reset test done");
    apb(1'b1, 8'h40, 32'h7f);
    op(OP_INC, 2'h0, 8'h0);
    rc(8'h40, 32'h80);
    rc(A_FLAGS, 32'hc);
    apb(1'b1, 8'h48, 32'hff);
    orr <= 2'h2;
    op(OP_INC, 2'h0, 8'h0);
    rc(8'h48, 32'h0);
    rc(A_FLAGS, 32'h3);
    apb(1'b1, 8'h48, 32'h7f);
    op(OP_INCREMENT_WITH_CARRY_OP, 2'h0, 8'h0);
    rc(A_FLAGS, 32'h4);
    op(OP_INCREMENT_WITH_CARRY_OP, 2'h0, 8'h0);
    rc(8'h48, 32'h80);
    rc(A_FLAGS, 32'h8);
    $display("increment test done");
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b1, A_PC, 32'hf0000);
    apb(1'b1, A_STACK, 32'h12345);
    ip <= 1'b1;
    @(posedge clk);
    #1;
    chk({31'h0, ia}, 32'h0);
    op(OP_INTERRUPT_RETURN_OP, 2'h0, 8'h0);
    chk({12'h0, pc}, 32'hf2345);
    chk({24'h0, sp, sr}, 32'h2);
    chk({31'h0, ia}, 32'h1);
    rc(A_FLAGS, 32'h8);
    apb(1'b1, A_CFG, 32'h1);
    apb(1'b1, A_STACK, 32'habcde);
    op(OP_INTERRUPT_RETURN_OP, 2'h0, 8'h0);
    chk({12'h0, pc}, 32'habcde);
    $display("return test done");
    apb(1'b1, 8'h70, 32'h1);
    orr <= 2'h0;
    op(OP_LOOP, 2'h3, 8'hfc);
    chk({31'h0, ds}, 32'h1);
    chk({31'h0, ia}, 32'h0);
    op(OP_INC, 2'h0, 8'h0);
    chk({12'h0, pc}, 32'habcdb);
    rc(8'h70, 32'h0);
    op(OP_LOOP, 2'h3, 8'hfc);
    chk({31'h0, ds}, 32'h0);
    op(OP_INC, 2'h0, 8'h0);
    rc(8'h40, 32'h82);
    rc(8'h70, 32'hff);
    op(OP_LOOP, 2'h0, 8'hfc);
    chk({31'h0, il}, 32'h1);
    rc(8'h40, 32'h82);
    $display("loop test done");
    summarize();
  end
endmodule
`default_nettype wire
